// file: shared/twi_pkg.sv
// Shared types and constants for the two-wire register slave
//
// Overview of operation
// RQ1: Strap selects serial port or parallel port
// RQ2: Serial clock works up to 400 kHz
// RQ3: Device is slave only, never starts transfers
// RQ4: SDA falling while SCL high means START
// RQ5: SDA rising while SCL high means STOP
// RQ6: SDA stable through SCL high; sample then
// RQ7: SDA change during SCL high is control
// RQ8: SCL input only; SDA pulled low or released
// RQ9: Eight-bit bytes, each followed by acknowledge
// RQ10: Acknowledge holds SDA low through clock high
// RQ11: Read/write bit zero marks a write
// RQ12: Word address loads counter, then acknowledged
// RQ13: Write data bytes stored and acknowledged; when the write buffer is full the code drops the byte and nacks it
// RQ14: Master ends write with STOP
// RQ15: Counter increments after each written byte
// RQ16: Read/write bit one marks a read
// RQ17: Master sets address with write phase first
// RQ18: Master repeats START then reads
// RQ19: Acknowledge read address, shift out register
// RQ20: Master acknowledge requests another byte
// RQ21: Master nack plus STOP ends read
// RQ22: Foreign address not acknowledged; wait START
// RQ23: Counter increments after each sent byte
// RQ24: Seven address bits, then R/W, MSB first
package twi_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_KHZ   = 250000;
	localparam int SCL_MAX_KHZ   = 400;
	localparam int SCL_PERIOD_CYC = SYS_CLK_KHZ / SCL_MAX_KHZ;

	// ------------------------------------------------------------
	// Counts and defaults
	// ------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'h7;
	localparam logic [6:0] OWN_ADDR_DEF = 7'h2c; // Arbitrary value

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_RXACK = 3'b010,
		ST_TX    = 3'b011,
		ST_TXACK = 3'b100
	} link_st_e;

	typedef enum logic [1:0] {
		SG_DEV  = 2'b00,
		SG_WORD = 2'b01,
		SG_DATA = 2'b10
	} stage_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} wr_req_s;

	typedef struct packed {
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic [1:0] sel_sy;
		logic       scl_d;
		logic       sda_d;
		link_st_e   st;
		stage_e     stage;
		logic [7:0] shreg;
		logic [3:0] cnt;
		logic       rw;
		logic       acked;
		logic       mack;
		logic [7:0] ptr;
		logic       oe_n;
		logic       push;
		wr_req_s    req;
	} link_s;

	typedef struct packed {
		wr_req_s head;
		logic    head_v;
		wr_req_s tail;
		logic    tail_v;
	} buf_s;

	localparam link_s LINK_RST = '{
		scl_sy: 2'h3, sda_sy: 2'h3, sel_sy: 2'h0, scl_d: 1'b1,
		sda_d: 1'b1, st: ST_IDLE, stage: SG_DEV, shreg: 8'h00,
		cnt: 4'h0, rw: 1'b0, acked: 1'b0, mack: 1'b0, ptr: 8'h00,
		oe_n: 1'b1, push: 1'b0, req: 16'h0000};
	localparam buf_s BUF_RST = '0;

endpackage : twi_pkg

// file: core/twi_wr_buf.sv
// Two-entry write buffer between the serial slave and the register file
`timescale 1ns/100ps
module twi_wr_buf
	import twi_pkg::*;
(
	// Clock and reset
	input  wire logic    sys_clk,
	input  wire logic    rst,
	// Fill side
	input  wire logic    in_valid,
	input  wire wr_req_s in_req,
	output logic         in_ready,
	// Drain side
	output logic         out_valid,
	output wr_req_s      out_req,
	input  wire logic    out_ready
);

	buf_s r;
	buf_s n;
	logic push;
	logic pop;

	assign push      = in_valid & ~r.tail_v;
	assign pop       = r.head_v & out_ready;
	assign in_ready  = ~r.tail_v;
	assign out_valid = r.head_v;
	assign out_req   = r.head;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		if (pop) begin
			n.head_v = 1'b0;
		end
		// Keep order: the older tail word moves up first
		if (!n.head_v && r.tail_v) begin
			n.head   = r.tail;
			n.head_v = 1'b1;
			n.tail_v = 1'b0;
		end
		if (push) begin // [RQ13]
			if (!n.head_v) begin
				n.head   = in_req;
				n.head_v = 1'b1;
			end else begin
				n.tail   = in_req;
				n.tail_v = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= BUF_RST;
		end else begin
			r <= n;
		end
	end

	chk_buf_full_stall: assert property (@(posedge sys_clk) disable iff (rst)
		(r.head_v && r.tail_v && !out_ready) |=> (r.head_v && r.tail_v
		&& !in_ready && $stable(r.head))) // [RQ13]
		else $error("Full buffer lost or moved a word");

endmodule : twi_wr_buf

// file: core/two_wire_register_slave.sv
// Two-wire serial slave port reaching the internal register file
`timescale 1ns/100ps
module two_wire_register_slave
	import twi_pkg::*;
#(
	parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF
)(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Serial pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// Port strap, high selects the serial port
	input  wire logic       port_select_strap,
	// Register write stream
	output logic            wr_valid,
	output wr_req_s         wr_req,
	input  wire logic       wr_ready,
	// Register read port
	output logic [7:0]      rd_addr,
	input  wire logic [7:0] rd_data
);

	link_s r;
	link_s n;
	logic  scl_s;
	logic  sda_s;
	logic  serial;
	logic  scl_rise;
	logic  scl_fall;
	logic  start_ev;
	logic  stop_ev;
	logic  buf_ready;

	// ------------------------------------------------------------
	// Bus event decode
	// ------------------------------------------------------------
	// Second synchroniser stage only; first stage feeds nothing else
	assign scl_s    = r.scl_sy[1];
	assign sda_s    = r.sda_sy[1];
	assign serial   = r.sel_sy[1];
	assign scl_rise = scl_s & ~r.scl_d;
	assign scl_fall = ~scl_s & r.scl_d;
	// SDA edges under a high clock are control, never data
	assign start_ev = scl_s & r.scl_d & r.sda_d & ~sda_s; // [RQ4] [RQ7]
	assign stop_ev  = scl_s & r.scl_d & ~r.sda_d & sda_s; // [RQ5] [RQ7]

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Open-drain: only ever pulls low, SCL is never driven
	assign sda_out  = 1'b0; // [RQ8]
	assign sda_oe_n = r.oe_n;
	assign rd_addr  = r.ptr;

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.push = 1'b0;
		// Oversampled at 250 MHz, far above any 400 kHz clock
		n.scl_sy = {r.scl_sy[0], scl_in}; // [RQ2]
		n.sda_sy = {r.sda_sy[0], sda_in};
		n.sel_sy = {r.sel_sy[0], port_select_strap};
		n.scl_d  = scl_s;
		n.sda_d  = sda_s;

		if (!serial) begin
			// Parallel port owns the registers
			n.st   = ST_IDLE; // [RQ1]
			n.oe_n = 1'b1;
		end else if (stop_ev) begin
			n.st   = ST_IDLE; // [RQ5] [RQ14] [RQ21]
			n.oe_n = 1'b1;
		end else if (start_ev) begin
			// Repeated START lands here too, keeping the counter
			n.st    = ST_RX; // [RQ4] [RQ18]
			n.stage = SG_DEV;
			n.cnt   = 4'h0;
			n.oe_n  = 1'b1;
		end else begin
			case (r.st)
			ST_IDLE: begin
				// Waits here for a START; never drives the bus
				n.oe_n = 1'b1; // [RQ3] [RQ22]
			end
			ST_RX: begin
				if (scl_rise && r.cnt != BYTE_BITS) begin
					// Sampled in the high phase, MSB first
					n.shreg = {r.shreg[6:0], sda_s}; // [RQ6] [RQ24]
					n.cnt   = r.cnt + 4'h1;
				end else if (scl_fall && r.cnt == BYTE_BITS) begin
					n.st  = ST_RXACK; // [RQ9]
					n.cnt = 4'h0;
					case (r.stage)
					SG_DEV: begin
						n.acked = (r.shreg[7:1] == OWN_ADDR); // [RQ22]
						n.rw    = r.shreg[0]; // [RQ11] [RQ16]
					end
					SG_WORD: begin
						n.acked = 1'b1;
						n.ptr   = r.shreg; // [RQ12] [RQ17]
					end
					default: begin
						// Full buffer: byte refused with a nack
						n.acked = buf_ready;
						if (buf_ready) begin
							n.push = 1'b1; // [RQ13]
							n.req  = '{addr: r.ptr, data: r.shreg};
							n.ptr  = r.ptr + 8'h01; // [RQ15]
						end
					end
					endcase
					n.oe_n = ~n.acked; // [RQ10]
				end
			end
			ST_RXACK: begin
				// Held low from fall to fall spans the whole high phase
				if (scl_fall) begin
					if (!r.acked) begin
						n.st   = ST_IDLE; // [RQ22]
						n.oe_n = 1'b1;
					end else if (r.stage == SG_DEV && r.rw) begin
						n.st    = ST_TX; // [RQ19]
						n.shreg = rd_data;
						n.cnt   = 4'h0;
						n.oe_n  = rd_data[7];
					end else begin
						n.st    = ST_RX;
						n.stage = (r.stage == SG_DEV) ? SG_WORD : SG_DATA;
						n.oe_n  = 1'b1;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (r.cnt == TX_LAST_BIT) begin
						n.st   = ST_TXACK;
						n.oe_n = 1'b1;
						n.ptr  = r.ptr + 8'h01; // [RQ23]
					end else begin
						n.shreg = {r.shreg[6:0], 1'b0};
						n.oe_n  = r.shreg[6]; // [RQ8] [RQ19]
						n.cnt   = r.cnt + 4'h1;
					end
				end
			end
			ST_TXACK: begin
				if (scl_rise) begin
					n.mack = ~sda_s;
				end else if (scl_fall) begin
					if (r.mack) begin
						n.st    = ST_TX; // [RQ20]
						n.shreg = rd_data;
						n.cnt   = 4'h0;
						n.oe_n  = rd_data[7];
					end else begin
						// Master nack: release and wait for STOP
						n.st   = ST_IDLE; // [RQ21]
						n.oe_n = 1'b1;
					end
				end
			end
			default: begin
				n.st   = ST_IDLE;
				n.oe_n = 1'b1;
			end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= LINK_RST;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// Write buffer
	// ------------------------------------------------------------
	twi_wr_buf u_wr_buf (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (r.push),
		.in_req    (r.req),
		.in_ready  (buf_ready),
		.out_valid (wr_valid),
		.out_req   (wr_req),
		.out_ready (wr_ready)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence byte_done;
		r.st == ST_RX && scl_fall && r.cnt == BYTE_BITS;
	endsequence

	sequence addr_mine;
		byte_done and (r.stage == SG_DEV && r.shreg[7:1] == OWN_ADDR);
	endsequence

	sequence addr_foreign;
		byte_done and (r.stage == SG_DEV && r.shreg[7:1] != OWN_ADDR);
	endsequence

	chk_strap_blocks: assert property (@(posedge sys_clk) disable iff (rst)
		!serial |=> (r.st == ST_IDLE && r.oe_n)) // [RQ1]
		else $error("Serial port active while strap deselects it");

	chk_idle_silent: assert property (@(posedge sys_clk) disable iff (rst)
		r.st == ST_IDLE |-> r.oe_n) // [RQ3]
		else $error("SDA driven while idle");

	chk_start_enter: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && start_ev) |=> (r.st == ST_RX && r.stage == SG_DEV
		&& r.cnt == 4'h0 && r.oe_n)) // [RQ4]
		else $error("START not taken");

	chk_stop_release: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && stop_ev) |=> (r.st == ST_IDLE && r.oe_n)) // [RQ5]
		else $error("STOP did not end the transfer");

	chk_high_stable: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && scl_s && r.scl_d && !start_ev && !stop_ev)
		|=> $stable(r.oe_n)) // [RQ6]
		else $error("SDA drive changed while SCL high");

	chk_addr_ack: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && !start_ev && !stop_ev) ##0 addr_mine
		|=> (r.st == ST_RXACK && !r.oe_n && r.rw == $past(r.shreg[0])))
		// [RQ10] [RQ24]
		else $error("Own address not acknowledged");

	chk_foreign_nack: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && !start_ev && !stop_ev) ##0 addr_foreign
		|=> r.oe_n ##1 (r.oe_n [*3])) // [RQ22]
		else $error("Foreign address acknowledged");

	chk_word_load: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && !start_ev && !stop_ev && r.stage == SG_WORD) ##0 byte_done
		|=> (r.ptr == $past(r.shreg) && !r.oe_n)) // [RQ12]
		else $error("Word address not loaded");

	chk_write_push: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && !start_ev && !stop_ev && r.stage == SG_DATA && buf_ready)
		##0 byte_done |=> (r.push && r.req.addr == $past(r.ptr)
		&& r.ptr == $past(r.ptr) + 8'h01)) // [RQ13] [RQ15]
		else $error("Write byte not stored or counter not advanced");

	chk_read_first: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && !start_ev && !stop_ev && r.st == ST_RXACK && scl_fall
		&& r.acked && r.stage == SG_DEV && r.rw)
		|=> (r.st == ST_TX && r.oe_n == $past(rd_data[7]))) // [RQ19]
		else $error("Read data not started");

	chk_tx_advance: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && !start_ev && !stop_ev && r.st == ST_TX && scl_fall
		&& r.cnt == TX_LAST_BIT)
		|=> (r.st == ST_TXACK && r.oe_n && r.ptr == $past(r.ptr) + 8'h01))
		// [RQ23]
		else $error("Counter not advanced after sent byte");

	chk_master_nack: assert property (@(posedge sys_clk) disable iff (rst)
		(serial && !start_ev && !stop_ev && r.st == ST_TXACK && scl_fall)
		|=> (r.mack ? r.st == ST_TX : (r.st == ST_IDLE && r.oe_n)))
		// [RQ20] [RQ21]
		else $error("Wrong reaction to master acknowledge");

endmodule : two_wire_register_slave

// file: bench/twi_master_model.sv
// Two-wire bus master model facing the serial slave
`timescale 1ns/100ps
module twi_master_model #(
	parameter int HALF = 4
)(
	// Clock
	input  wire logic sys_clk,
	// Bus lines
	input  wire logic sda,
	output logic      scl,
	output logic      sda_oe_n
);
	// ----------------------------------------
	// Idle bus: clock parked high, data let go
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sda_oe_n = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wt

	// Data moves one cycle after the fall, never with it,
	// so the slave cannot mistake it for a START or STOP.
	// One bit spans 2*HALF cycles: a 32 ns clock at 4 ns.
	task automatic bit_io(input logic b, output logic r);
		wt(1);
		sda_oe_n <= b;
		wt(HALF - 1);
		scl <= 1'b1;
		wt(HALF);
		r = sda;
		scl <= 1'b0;
	endtask : bit_io

	// Longer low phase lets the slave drop its acknowledge first
	task automatic start();
		wt(1);
		sda_oe_n <= 1'b1;
		wt(HALF);
		scl <= 1'b1;
		wt(HALF);
		sda_oe_n <= 1'b0;
		wt(HALF);
		scl <= 1'b0;
	endtask : start

	task automatic stop();
		wt(1);
		sda_oe_n <= 1'b0;
		wt(HALF - 1);
		scl <= 1'b1;
		wt(HALF);
		sda_oe_n <= 1'b1;
		wt(HALF);
	endtask : stop

	task automatic xfer(input logic [7:0] d, input logic ai,
		output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ai, ao);
	endtask : xfer
endmodule : twi_master_model

// file: bench/two_wire_register_slave_tb.sv
// Self-checking bench for the two-wire register slave
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
	err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module two_wire_register_slave_tb import twi_pkg::*;;
	localparam logic [7:0] WA = {OWN_ADDR_DEF, 1'b0};
	localparam logic [7:0] RA = {OWN_ADDR_DEF, 1'b1};
	logic       sys_clk, rst, scl, m_oe_n, sda_oe_n, sda_out;
	logic       strap, wr_ready, wr_valid, ack;
	wr_req_s    wr_req;
	logic [7:0] rd_addr, q;
	logic [7:0] mem [256];
	int         err_total, check_count;
	// Pull-up: low if either party pulls
	wire        sda = (sda_oe_n ? 1'b1 : sda_out) & m_oe_n;

	two_wire_register_slave dut (.sys_clk(sys_clk), .rst(rst),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .port_select_strap(strap),
		.wr_valid(wr_valid), .wr_req(wr_req), .wr_ready(wr_ready),
		.rd_addr(rd_addr), .rd_data(mem[rd_addr]));
	twi_master_model mst (.sys_clk(sys_clk), .sda(sda), .scl(scl),
		.sda_oe_n(m_oe_n));

	// ----------------------------------------
	// Register file beside the write stream
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = ~8'(i);
		end
	end
	always @(posedge sys_clk) begin
		if (wr_valid && wr_ready) begin
			mem[wr_req.addr] <= wr_req.data;
		end
	end

	task automatic snd(input logic [7:0] d, input logic e);
		mst.xfer(d, 1'b1, q, ack);
		`CHK(ack, e)
	endtask : snd

	task automatic t_write();
		mst.start();
		snd(WA, 1'b0);
		snd(8'hfe, 1'b0);
		snd(8'ha1, 1'b0);
		snd(8'hb2, 1'b0);
		snd(8'hc3, 1'b0);
		mst.stop();
		mst.wt(8);
		`CHK(mem[8'hfe], 8'ha1)
		`CHK(mem[8'hff], 8'hb2)
		`CHK(mem[8'h00], 8'hc3)
		`CHK(rd_addr, 8'h01)
		`CHK(sda_oe_n, 1'b1)
		$display("write test done");
	endtask : t_write

	task automatic t_read();
		mst.start();
		snd(WA, 1'b0);
		snd(8'hfe, 1'b0);
		mst.start();
		snd(RA, 1'b0);
		for (int i = 0; i < 3; i++) begin
			mst.xfer(8'hff, i == 2, q, ack);
			`CHK(q, mem[8'(8'hfe + i)])
		end
		mst.stop();
		`CHK(sda_oe_n, 1'b1)
		`CHK(rd_addr, 8'h01)
		$display("read test done");
	endtask : t_read

	task automatic t_foreign();
		mst.start();
		snd({OWN_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1);
		snd(8'h10, 1'b1);
		mst.stop();
		`CHK(mem[8'h10], 8'hef)
		$display("foreign test done");
	endtask : t_foreign

	task automatic t_strap();
		strap <= 1'b0;
		mst.wt(8);
		mst.start();
		snd(WA, 1'b1);
		mst.stop();
		strap <= 1'b1;
		mst.wt(8);
		$display("strap test done");
	endtask : t_strap

	// Stalled receiver: two words fit, the third is refused
	task automatic t_stall();
		wr_ready <= 1'b0;
		mst.start();
		snd(WA, 1'b0);
		snd(8'h20, 1'b0);
		snd(8'h11, 1'b0);
		snd(8'h22, 1'b0);
		snd(8'h33, 1'b1);
		mst.stop();
		`CHK(wr_valid, 1'b1)
		wr_ready <= 1'b1;
		mst.wt(8);
		`CHK(mem[8'h20], 8'h11)
		`CHK(mem[8'h21], 8'h22)
		`CHK(mem[8'h22], 8'hdd)
		$display("stall test done");
	endtask : t_stall

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// Clock, reset, sequence and watchdog
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		rst = 1'b1;
		strap = 1'b1;
		wr_ready = 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		mst.wt(8);
		t_write();
		t_read();
		t_foreign();
		t_strap();
		t_stall();
		stop_test();
	end
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
endmodule : two_wire_register_slave_tb
